// ===== hw/ckm_cdiv.sv
// gated clock divider on a sampled clock level; ratio 0 stops, 1 passes
// assumes src_i is a level that changes no faster than clk_i/2
`timescale 1ns/10ps
module ckm_cdiv (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // source, gate, ratio
  input  wire logic       src_i,
  input  wire logic       run_i,
  input  wire logic [7:0] div_i,
  // divided clock
  output logic            clk_o
);
  logic       src_d_r;
  logic       run_r;
  logic [7:0] div_r;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       rise;

  assign rise    = src_i & !src_d_r;
  assign cnt_nxt = (cnt_r >= div_r - 8'h01) ? 8'h00 : cnt_r + 8'h01;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      src_d_r <= 1'b0;
    end else begin
      src_d_r <= src_i;
    end
  end

  // gate and ratio only change while the output is low, so no runt pulse
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_r <= 1'b0;
      div_r <= 8'h01;
    end else if (!clk_o && !src_i) begin
      run_r <= run_i;
      div_r <= div_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 8'h00;
      clk_o <= 1'b0;
    end else if (div_r == 8'h00 || !run_r) begin
      cnt_r <= 8'h00;
      clk_o <= 1'b0;
    end else if (div_r == 8'h01) begin
      clk_o <= src_i;
    end else if (rise) begin
      cnt_r <= cnt_nxt;
      clk_o <= (cnt_nxt < {1'b0, div_r[7:1]});
    end
  end
endmodule

// ===== hw/ckm_clock_ctrl.sv
// clock generation and power control: source selection, pll control,
// clock output, cpu divider, peripheral gating and sleep
// assumes software drives the config ports with one-cycle write strobes
`timescale 1ns/10ps
module ckm_clock_ctrl
  import ckm_pkg::*;
#(
  parameter int SETTLE_CYC = ckm_pkg::PLL_SETTLE_CYC
) (
  // clock and reset
  input  wire logic                          CLK_I,
  input  wire logic                          RSTN_I,
  // oscillator and pll clock levels
  input  wire logic                          INTERNAL_RC_OSC_I,
  input  wire logic                          CRYSTAL_OSC_I,
  input  wire logic                          LOW_FREQ_OSC_I,
  input  wire logic                          WATCHDOG_RING_OSC_I,
  input  wire logic                          PLL_CLK_I,
  // source selection
  input  wire logic [1:0]                    MAIN_SEL_I,
  input  wire logic                          MAIN_SEL_WE_I,
  input  wire logic [1:0]                    CLOCK_OUTPUT_PIN_SEL_I,
  input  wire logic                          CLOCK_OUTPUT_PIN_SEL_WE_I,
  input  wire logic                          WDT_SEL_I,
  input  wire logic                          WDT_SEL_WE_I,
  // oscillator control
  input  wire logic [ckm_pkg::OSC_EN_W-1:0]  OSC_EN_I,
  input  wire logic                          OSC_EN_WE_I,
  input  wire logic [ckm_pkg::FREQ_W-1:0]    LFO_FREQ_I,
  input  wire logic [ckm_pkg::FREQ_W-1:0]    WDO_FREQ_I,
  input  wire logic                          FREQ_WE_I,
  // pll control
  input  wire logic                          PLL_EN_I,
  input  wire logic                          PLL_EN_WE_I,
  input  wire logic                          PLL_REF_SEL_I,
  input  wire logic [ckm_pkg::MULT_W-1:0]    PLL_MULT_I,
  input  wire logic [1:0]                    PLL_LOOP_DIV_I,
  input  wire logic [1:0]                    PLL_POST_DIV_I,
  input  wire logic                          PLL_CFG_WE_I,
  // dividers and gating
  input  wire logic [ckm_pkg::DIV_W-1:0]     CPU_DIV_I,
  input  wire logic                          CPU_DIV_WE_I,
  input  wire logic [ckm_pkg::NPERIPH-1:0]   PERIPH_GATE_I,
  input  wire logic                          PERIPH_GATE_WE_I,
  input  wire logic [ckm_pkg::DIV_W-1:0]     PERIPH_DIV_I,
  input  wire logic [0:0]                    PERIPH_DIV_IDX_I,
  input  wire logic                          PERIPH_DIV_WE_I,
  // sleep
  input  wire logic                          SLEEP_REQ_I,
  input  wire logic                          WAKE_I,
  // oscillator outputs
  output logic                               CRYSTAL_OSC_EN_O,
  output logic                               LOW_FREQ_OSC_EN_O,
  output logic                               WATCHDOG_RING_OSC_EN_O,
  output logic [ckm_pkg::FREQ_W-1:0]         LFO_FREQ_O,
  output logic [ckm_pkg::FREQ_W-1:0]         WDO_FREQ_O,
  // pll outputs
  output logic                               PLL_PD_O,
  output logic                               PLL_BYPASS_O,
  output logic                               PLL_REF_CLK_O,
  output logic [ckm_pkg::MULT_W-1:0]         PLL_MULT_O,
  output logic [1:0]                         PLL_LOOP_DIV_O,
  output logic [1:0]                         PLL_POST_DIV_O,
  output logic [4:0]                         PLL_POST_RATIO_O,
  output logic                               PLL_LOCK_O,
  // clock outputs
  output logic                               CORE_CLK_O,
  output logic                               CLOCK_OUTPUT_PIN_O,
  output logic                               WDT_CLK_O,
  output logic [ckm_pkg::NPERIPH-1:0]        PERIPH_CLK_O,
  // status
  output logic [1:0]                         MAIN_SRC_O,
  output logic                               MAIN_SW_BUSY_O,
  output logic                               SLEEPING_O
);
  import ckm_pkg::*;

  logic [1:0]          main_sel_r;
  logic [1:0]          clock_output_pin_sel_r;
  logic                wdt_sel_r;
  logic [OSC_EN_W-1:0] osc_en_r;
  logic [FREQ_W-1:0]   lfo_freq_r;
  logic [FREQ_W-1:0]   wdo_freq_r;
  logic                pll_pd_r;
  logic                pll_ref_r;
  logic [MULT_W-1:0]   pll_mult_r;
  logic [1:0]          pll_ldiv_r;
  logic [1:0]          pll_pdiv_r;
  logic [LOCK_CNT_W-1:0] lock_cnt_r;
  logic                lock_r;
  logic [DIV_W-1:0]    cpu_div_r;
  logic [NPERIPH-1:0]  gate_r;
  logic [DIV_W-1:0]    pdiv_r [NPDIV];
  logic                sleep_r;
  logic [NPERIPH-1:0]  pclk_r;
  logic                main_clk;
  logic                pll_ref_clk;
  logic [1:0]          main_cur;
  logic                pll_change;

  // oscillators: internal rc always runs, the rest start off
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      osc_en_r <= OSC_EN_RST;
    end else if (OSC_EN_WE_I) begin
      osc_en_r <= OSC_EN_I;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      lfo_freq_r <= FREQ_RST;
      wdo_freq_r <= FREQ_RST;
    end else if (FREQ_WE_I) begin
      lfo_freq_r <= LFO_FREQ_I;
      wdo_freq_r <= WDO_FREQ_I;
    end
  end

  assign CRYSTAL_OSC_EN_O       = osc_en_r[OSC_XTAL_B];
  assign LOW_FREQ_OSC_EN_O      = osc_en_r[OSC_LFO_B];
  assign WATCHDOG_RING_OSC_EN_O = osc_en_r[OSC_WDO_B];
  assign LFO_FREQ_O             = lfo_freq_r;
  assign WDO_FREQ_O             = wdo_freq_r;

  // pll enable and settings; range limits on reference and cco are the
  // programmer's duty, the block only carries the fields to the analog part
  assign pll_change = PLL_CFG_WE_I &&
                      (PLL_REF_SEL_I != pll_ref_r || PLL_MULT_I != pll_mult_r ||
                       PLL_LOOP_DIV_I != pll_ldiv_r || PLL_POST_DIV_I != pll_pdiv_r);

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pll_pd_r <= 1'b1;
    end else if (PLL_EN_WE_I) begin
      pll_pd_r <= !PLL_EN_I;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pll_ref_r  <= REF_IRC;
      pll_mult_r <= MULT_RST;
      pll_ldiv_r <= LDIV_RST;
      pll_pdiv_r <= PDIV_RST;
    end else if (PLL_CFG_WE_I) begin
      pll_ref_r  <= PLL_REF_SEL_I;
      pll_mult_r <= PLL_MULT_I;
      pll_ldiv_r <= PLL_LOOP_DIV_I;
      pll_pdiv_r <= PLL_POST_DIV_I;
    end
  end

  assign PLL_PD_O         = pll_pd_r;
  assign PLL_BYPASS_O     = pll_pd_r;
  assign PLL_MULT_O       = pll_mult_r;
  assign PLL_LOOP_DIV_O   = pll_ldiv_r;
  assign PLL_POST_DIV_O   = pll_pdiv_r;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PLL_POST_RATIO_O <= 5'h02;
    end else begin
      PLL_POST_RATIO_O <= post_ratio(pll_pdiv_r);
    end
  end

  // lock after the settling time; lost on disable or any setting change
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      lock_cnt_r <= '0;
      lock_r     <= 1'b0;
    end else if (pll_pd_r || pll_change || (PLL_EN_WE_I && !PLL_EN_I)) begin
      lock_cnt_r <= '0;
      lock_r     <= 1'b0;
    end else if (lock_cnt_r == LOCK_CNT_W'(SETTLE_CYC - 1)) begin
      lock_r     <= 1'b1;
    end else begin
      lock_cnt_r <= lock_cnt_r + LOCK_CNT_W'(1);
    end
  end

  assign PLL_LOCK_O = lock_r;

  // main clock select; the pll output is taken only once locked, and a lost
  // lock falls back to the internal rc once the main mux drops the pll while it is low
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      main_sel_r <= SRC_IRC;
    end else if (main_sel_r == SRC_PLL && !lock_r) begin
      main_sel_r <= SRC_IRC;
    end else if (MAIN_SEL_WE_I && (MAIN_SEL_I != SRC_PLL || lock_r)) begin
      main_sel_r <= MAIN_SEL_I;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      clock_output_pin_sel_r <= SRC_IRC;
      wdt_sel_r    <= WDT_IRC;
    end else begin
      if (CLOCK_OUTPUT_PIN_SEL_WE_I) begin
        clock_output_pin_sel_r <= CLOCK_OUTPUT_PIN_SEL_I;
      end
      if (WDT_SEL_WE_I) begin
        wdt_sel_r <= WDT_SEL_I;
      end
    end
  end

  // pll reference: internal rc or crystal
  ckm_gfmux u_ref_mux (
    .clk_i  (CLK_I),
    .rstn_i (RSTN_I),
    .src_i  ({2'b00, CRYSTAL_OSC_I, INTERNAL_RC_OSC_I}),
    .sel_i  ({1'b0, pll_ref_r}),
    .clk_o  (pll_ref_clk),
    .cur_o  (),
    .busy_o ()
  );

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PLL_REF_CLK_O <= 1'b0;
    end else begin
      PLL_REF_CLK_O <= pll_ref_clk & !pll_pd_r;
    end
  end

  ckm_gfmux u_main_mux (
    .clk_i  (CLK_I),
    .rstn_i (RSTN_I),
    .src_i  ({PLL_CLK_I, LOW_FREQ_OSC_I, CRYSTAL_OSC_I, INTERNAL_RC_OSC_I}),
    .sel_i  (main_sel_r),
    .clk_o  (main_clk),
    .cur_o  (main_cur),
    .busy_o (MAIN_SW_BUSY_O)
  );

  assign MAIN_SRC_O = main_cur;

  // the main clock slot of the output selector uses the main mux result
  ckm_gfmux u_out_mux (
    .clk_i  (CLK_I),
    .rstn_i (RSTN_I),
    .src_i  ({main_clk, LOW_FREQ_OSC_I, CRYSTAL_OSC_I, INTERNAL_RC_OSC_I}),
    .sel_i  (clock_output_pin_sel_r),
    .clk_o  (CLOCK_OUTPUT_PIN_O),
    .cur_o  (),
    .busy_o ()
  );

  // the watchdog ring oscillator reaches no other consumer
  ckm_gfmux u_wdt_mux (
    .clk_i  (CLK_I),
    .rstn_i (RSTN_I),
    .src_i  ({2'b00, WATCHDOG_RING_OSC_I, INTERNAL_RC_OSC_I}),
    .sel_i  ({1'b0, wdt_sel_r}),
    .clk_o  (WDT_CLK_O),
    .cur_o  (),
    .busy_o ()
  );

  // sleep: a wake in the same cycle as a request wins
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sleep_r <= 1'b0;
    end else if (WAKE_I) begin
      sleep_r <= 1'b0;
    end else if (SLEEP_REQ_I) begin
      sleep_r <= 1'b1;
    end
  end

  assign SLEEPING_O = sleep_r;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cpu_div_r <= CPU_DIV_RST;
    end else if (CPU_DIV_WE_I) begin
      cpu_div_r <= CPU_DIV_I;
    end
  end

  // only the core clock sees the sleep gate
  ckm_cdiv u_cpu_div (
    .clk_i  (CLK_I),
    .rstn_i (RSTN_I),
    .src_i  (main_clk),
    .run_i  (!sleep_r),
    .div_i  (cpu_div_r),
    .clk_o  (CORE_CLK_O)
  );

  // peripheral gates and local dividers
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      gate_r <= GATE_RST;
    end else if (PERIPH_GATE_WE_I) begin
      gate_r <= PERIPH_GATE_I;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pdiv_r[0] <= PER_DIV_RST;
      pdiv_r[1] <= PER_DIV_RST;
    end else if (PERIPH_DIV_WE_I) begin
      pdiv_r[PERIPH_DIV_IDX_I] <= PERIPH_DIV_I;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPERIPH; gi++) begin : g_pclk
      if (gi < NPDIV) begin : g_div
        // divider sits after the gate; sleep does not reach it
        ckm_cdiv u_pdiv (
          .clk_i  (CLK_I),
          .rstn_i (RSTN_I),
          .src_i  (main_clk),
          .run_i  (gate_r[gi]),
          .div_i  (pdiv_r[gi]),
          .clk_o  (pclk_r[gi])
        );
      end else begin : g_gate
        // the gate may only open or close while the main clock is low
        logic en_r;
        always_ff @(posedge CLK_I or negedge RSTN_I) begin
          if (!RSTN_I) begin
            en_r <= 1'b0;
          end else if (!main_clk) begin
            en_r <= gate_r[gi];
          end
        end
        always_ff @(posedge CLK_I or negedge RSTN_I) begin
          if (!RSTN_I) begin
            pclk_r[gi] <= 1'b0;
          end else begin
            pclk_r[gi] <= en_r & main_clk;
          end
        end
      end
    end
  endgenerate

  assign PERIPH_CLK_O = pclk_r;
endmodule

// ===== hw/ckm_gfmux.sv
// glitch-free four-way clock selector
// assumes source clocks are levels sampled on clk_i, slower than clk_i/2
`timescale 1ns/10ps
module ckm_gfmux (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // sources and selection
  input  wire logic [3:0] src_i,
  input  wire logic [1:0] sel_i,
  // outputs
  output logic            clk_o,
  output logic [1:0]      cur_o,
  output logic            busy_o
);
  logic [1:0] cur_r;
  logic       en_r;

  // drop the old source only while it is low, pick up the new one only while low
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cur_r <= 2'h0;
      en_r  <= 1'b1;
    end else if (en_r) begin
      if (sel_i != cur_r && !src_i[cur_r]) begin
        en_r <= 1'b0;
      end
    end else if (cur_r != sel_i) begin
      cur_r <= sel_i;
    end else if (!src_i[cur_r]) begin
      en_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_o  <= 1'b0;
      cur_o  <= 2'h0;
      busy_o <= 1'b0;
    end else begin
      clk_o  <= en_r & src_i[cur_r];
      cur_o  <= cur_r;
      busy_o <= !en_r || (sel_i != cur_r);
    end
  end
endmodule

// ===== hw/ckm_pkg.sv
// constants shared by the clock generation and power control block
// assumes one 100 MHz system clock; oscillator and pll clocks arrive as sampled levels
// Summary of operation
// - main clock from internal rc after reset
// - four independent oscillator sources provided
// - internal rc 12 MHz, usable as pll reference
// - internal rc selectable for watchdog and pll
// - crystal drives cpu directly or via pll
// - low freq and watchdog osc frequency programmable
// - watchdog osc feeds only the watchdog
// - low freq osc drives cpu and clock output
// - pll reference range 10 to 25 MHz
// - pll multiplier any integer 1 to 32
// - in-loop divider keeps cco 156-320 MHz
// - post divider 2, 4, 8 or 16
// - pll powered down, bypassed after reset
// - enable pll, wait lock, then switch
// - clock output selects rc, crystal, lf, main
// - power-up runs from internal rc; wake resumes on the selected main clock
// - programmable cpu clock divider
// - per-peripheral clock gate bits
// - selected peripherals have own divider after gate
// - sleep stops only the core clock
// - peripheral clocks keep running in sleep
package ckm_pkg;
  // source codes of the main and clock-output selectors
  localparam logic [1:0] SRC_IRC     = 2'h0;
  localparam logic [1:0] SRC_CRYSTAL = 2'h1;
  localparam logic [1:0] SRC_LFO     = 2'h2;
  localparam logic [1:0] SRC_PLL     = 2'h3;
  localparam logic [1:0] SRC_MAIN    = 2'h3;
  // watchdog and pll reference selector codes
  localparam logic       WDT_IRC     = 1'h0;
  localparam logic       WDT_WDO     = 1'h1;
  localparam logic       REF_IRC     = 1'h0;
  localparam logic       REF_CRYSTAL = 1'h1;
  // oscillator figures
  localparam int IRC_MHZ        = 12;
  localparam int CRYSTAL_MIN_MHZ = 1;
  localparam int CRYSTAL_MAX_MHZ = 25;
  localparam int PLL_REF_MIN_MHZ = 10;
  localparam int PLL_REF_MAX_MHZ = 25;
  localparam int CCO_MIN_MHZ    = 156;
  localparam int CCO_MAX_MHZ    = 320;
  localparam int PLL_MULT_MAX   = 32;
  // field widths and positions
  localparam int OSC_EN_W   = 3;
  localparam int OSC_XTAL_B = 0;
  localparam int OSC_LFO_B  = 1;
  localparam int OSC_WDO_B  = 2;
  localparam int FREQ_W     = 4;
  localparam int MULT_W     = 5;
  localparam int DIV_W      = 8;
  localparam int NPERIPH    = 8;
  localparam int NPDIV      = 2;
  // reset values
  localparam logic [OSC_EN_W-1:0] OSC_EN_RST  = 3'h0;
  localparam logic [FREQ_W-1:0]   FREQ_RST    = 4'h1;
  localparam logic [MULT_W-1:0]   MULT_RST    = 5'h0;
  localparam logic [1:0]          LDIV_RST    = 2'h0;
  localparam logic [1:0]          PDIV_RST    = 2'h0;
  localparam logic [DIV_W-1:0]    CPU_DIV_RST = 8'h01;
  localparam logic [DIV_W-1:0]    PER_DIV_RST = 8'h01;
  localparam logic [NPERIPH-1:0]  GATE_RST    = 8'hFF;
  // timing
  localparam int CLK_MHZ         = 100;
  localparam int PLL_SETTLE_US   = 100;
  localparam int PLL_SETTLE_CYC  = PLL_SETTLE_US * CLK_MHZ;
  localparam int LOCK_CNT_W      = 16;
  // post divider code 0..3 gives ratio 2, 4, 8, 16
  function automatic logic [4:0] post_ratio(input logic [1:0] code);
    post_ratio = 5'h02 << code;
  endfunction
endpackage

// ===== tb/ckm_clock_ctrl_props.sv
// concurrent checks on the clock control block's ports
// assumes it is bound into the block with ports of the same names
`timescale 1ns/10ps
module ckm_clock_ctrl_chk
  import ckm_pkg::*;
(
  // clock and reset
  input wire logic               CLK_I,
  input wire logic               RSTN_I,
  // watched inputs
  input wire logic               PLL_EN_I,
  input wire logic               PLL_EN_WE_I,
  input wire logic [1:0]         PLL_POST_DIV_I,
  input wire logic               PLL_CFG_WE_I,
  input wire logic [NPERIPH-1:0] PERIPH_GATE_I,
  input wire logic               PERIPH_GATE_WE_I,
  input wire logic               SLEEP_REQ_I,
  input wire logic               WAKE_I,
  // watched outputs
  input wire logic               PLL_PD_O,
  input wire logic [1:0]         PLL_POST_DIV_O,
  input wire logic [4:0]         PLL_POST_RATIO_O,
  input wire logic               PLL_LOCK_O,
  input wire logic               CORE_CLK_O,
  input wire logic [NPERIPH-1:0] PERIPH_CLK_O,
  input wire logic [1:0]         MAIN_SRC_O,
  input wire logic               SLEEPING_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);

  chk_rst_state: assert property (
    $rose(RSTN_I) |-> MAIN_SRC_O == SRC_IRC && PLL_PD_O && !PLL_LOCK_O)
    else $error("state after reset release is wrong");
  chk_pll_power: assert property (
    PLL_EN_WE_I && PLL_EN_I |=> !PLL_PD_O)
    else $error("pll not powered after enable");
  chk_lock_drop: assert property (
    PLL_EN_WE_I && !PLL_EN_I |-> ##[1:2] !PLL_LOCK_O)
    else $error("lock stays after disable");
  chk_cfg_unlock: assert property (
    PLL_CFG_WE_I && PLL_POST_DIV_I != PLL_POST_DIV_O |-> ##[1:2] !PLL_LOCK_O)
    else $error("lock stays after divider change");
  chk_pll_locked: assert property (
    MAIN_SRC_O == SRC_PLL && $past(MAIN_SRC_O) != SRC_PLL |-> PLL_LOCK_O)
    else $error("main clock moved to unlocked pll");
  chk_post_ratio: assert property (
    PLL_POST_RATIO_O == (5'h02 << $past(PLL_POST_DIV_O)))
    else $error("post ratio does not follow code");
  chk_gate_stop: assert property (
    PERIPH_GATE_WE_I && !PERIPH_GATE_I[2] |-> ##[1:40] (!PERIPH_CLK_O[2]) [*8])
    else $error("gated peripheral clock still runs");
  chk_sleep_flag: assert property (
    SLEEP_REQ_I && !WAKE_I |=> SLEEPING_O)
    else $error("sleep not entered");
  chk_wake_flag: assert property (
    WAKE_I |=> !SLEEPING_O)
    else $error("wake not taken");
  chk_core_stop: assert property (
    $rose(SLEEPING_O) |-> ##[0:40] (!CORE_CLK_O) [*8])
    else $error("core clock runs in sleep");

  cov_lock: cover property ($rose(PLL_LOCK_O));
  cov_on_pll: cover property (MAIN_SRC_O == SRC_PLL);
  cov_sleep: cover property ($rose(SLEEPING_O));
endmodule

// ===== tb/ckm_osc_model.sv
// oscillator and pll level model feeding the clock control block
// assumes clk_i is the system clock; every phase lasts two cycles or more
`timescale 1ns/10ps
module ckm_osc_model (
  // clock
  input  wire logic clk_i,
  // controls from the block
  input  wire logic xtal_en_i,
  input  wire logic lfo_en_i,
  input  wire logic wdo_en_i,
  input  wire logic pll_pd_i,
  // oscillator levels
  output logic      rc_o,
  output logic      xtal_o,
  output logic      lfo_o,
  output logic      wdo_o,
  output logic      pll_o
);
  int cnt = 0;
  always @(posedge clk_i) cnt <= cnt + 1;
  // four oscillators and the pll; disabled ones stand still low
  assign rc_o   = (cnt % 6) < 3;
  assign xtal_o = xtal_en_i && (cnt % 8) < 4;
  assign lfo_o  = lfo_en_i && (cnt % 12) < 6;
  assign wdo_o  = wdo_en_i && (cnt % 10) < 5;
  assign pll_o  = !pll_pd_i && (cnt % 4) < 2;
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the clock control block: strobed writes, edge counts
// assumes the oscillator model; clock periods are counted over 96 cycles
`timescale 1ns/10ps
module tb_top;
  import ckm_pkg::*;
  localparam int SETTLE = 20;
  localparam int MAIN = 0, OUT = 1, PEN = 2, CFG = 3, WDT = 4, OSC = 5;
  localparam int FRQ = 6, CDIV = 7, GATE = 8, PDIV = 9, SLP = 10, WAK = 11;
  logic       CLK_I, RSTN_I, WDT_SEL_I, PLL_EN_I, PLL_REF_SEL_I;
  logic       MAIN_SEL_WE_I, CLOCK_OUTPUT_PIN_SEL_WE_I, WDT_SEL_WE_I, OSC_EN_WE_I, FREQ_WE_I;
  logic       PLL_EN_WE_I, PLL_CFG_WE_I, CPU_DIV_WE_I, PERIPH_GATE_WE_I;
  logic       PERIPH_DIV_WE_I, SLEEP_REQ_I, WAKE_I;
  logic [1:0] MAIN_SEL_I, CLOCK_OUTPUT_PIN_SEL_I, PLL_LOOP_DIV_I, PLL_POST_DIV_I;
  logic [2:0] OSC_EN_I;
  logic [3:0] LFO_FREQ_I, WDO_FREQ_I;
  logic [4:0] PLL_MULT_I;
  logic [7:0] CPU_DIV_I, PERIPH_GATE_I, PERIPH_DIV_I;
  logic [0:0] PERIPH_DIV_IDX_I;
  wire logic  INTERNAL_RC_OSC_I, CRYSTAL_OSC_I, LOW_FREQ_OSC_I, WATCHDOG_RING_OSC_I;
  wire logic  PLL_CLK_I, CRYSTAL_OSC_EN_O, LOW_FREQ_OSC_EN_O, WATCHDOG_RING_OSC_EN_O;
  wire logic  PLL_PD_O, PLL_BYPASS_O, PLL_REF_CLK_O, PLL_LOCK_O, CORE_CLK_O;
  wire logic  CLOCK_OUTPUT_PIN_O, WDT_CLK_O, MAIN_SW_BUSY_O, SLEEPING_O;
  wire logic [3:0] LFO_FREQ_O, WDO_FREQ_O;
  wire logic [4:0] PLL_MULT_O, PLL_POST_RATIO_O;
  wire logic [1:0] PLL_LOOP_DIV_O, PLL_POST_DIV_O, MAIN_SRC_O;
  wire logic [7:0] PERIPH_CLK_O;
  wire logic [11:0] clks = {PLL_REF_CLK_O, WDT_CLK_O, CLOCK_OUTPUT_PIN_O, CORE_CLK_O,
                            PERIPH_CLK_O};
  int failures = 0;
  int checks = 0;
  int c;
  int n;
  int per[4] = '{6, 8, 12, 12};

  ckm_clock_ctrl #(.SETTLE_CYC(SETTLE)) i_dut (.*);
  ckm_osc_model i_osc (
    .clk_i(CLK_I), .xtal_en_i(CRYSTAL_OSC_EN_O), .lfo_en_i(LOW_FREQ_OSC_EN_O),
    .wdo_en_i(WATCHDOG_RING_OSC_EN_O), .pll_pd_i(PLL_PD_O), .rc_o(INTERNAL_RC_OSC_I),
    .xtal_o(CRYSTAL_OSC_I), .lfo_o(LOW_FREQ_OSC_I), .wdo_o(WATCHDOG_RING_OSC_I),
    .pll_o(PLL_CLK_I));
  always #5 CLK_I = ~CLK_I;
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // edge counts vary by one with the oscillator phase
  task automatic near(input int got, input int e);
    chk(16'(got >= e - 1 && got <= e + 1), 16'h0001);
  endtask

  // one-cycle strobe k with its data taken from v
  task automatic wr(input int k, input logic [15:0] v);
    @(posedge CLK_I);
    case (k)
      MAIN: MAIN_SEL_I <= v[1:0];
      OUT: CLOCK_OUTPUT_PIN_SEL_I <= v[1:0];
      PEN: PLL_EN_I <= v[0];
      CFG: {PLL_REF_SEL_I, PLL_MULT_I, PLL_LOOP_DIV_I, PLL_POST_DIV_I} <= v[9:0];
      WDT: WDT_SEL_I <= v[0];
      OSC: OSC_EN_I <= v[2:0];
      FRQ: {WDO_FREQ_I, LFO_FREQ_I} <= v[7:0];
      CDIV: CPU_DIV_I <= v[7:0];
      GATE: PERIPH_GATE_I <= v[7:0];
      PDIV: {PERIPH_DIV_IDX_I, PERIPH_DIV_I} <= v[8:0];
      default: ;
    endcase
    {WAKE_I, SLEEP_REQ_I, PERIPH_DIV_WE_I, PERIPH_GATE_WE_I, CPU_DIV_WE_I, FREQ_WE_I,
     OSC_EN_WE_I, WDT_SEL_WE_I, PLL_CFG_WE_I, PLL_EN_WE_I, CLOCK_OUTPUT_PIN_SEL_WE_I,
     MAIN_SEL_WE_I} <= 12'h001 << k;
    @(posedge CLK_I);
    {WAKE_I, SLEEP_REQ_I, PERIPH_DIV_WE_I, PERIPH_GATE_WE_I, CPU_DIV_WE_I, FREQ_WE_I,
     OSC_EN_WE_I, WDT_SEL_WE_I, PLL_CFG_WE_I, PLL_EN_WE_I, CLOCK_OUTPUT_PIN_SEL_WE_I,
     MAIN_SEL_WE_I} <= 12'h000;
  endtask

  // rising edges of clks[k] over 96 cycles
  task automatic cnt(input int k, output int r);
    logic p;
    r = 0;
    @(negedge CLK_I);
    p = clks[k];
    repeat (96) begin
      @(negedge CLK_I);
      if (clks[k] && !p) r++;
      p = clks[k];
    end
  endtask

  task automatic wait_src(input logic [1:0] s);
    int i;
    i = 0;
    @(negedge CLK_I);
    while (i < 200 && (MAIN_SRC_O !== s || MAIN_SW_BUSY_O !== 1'b0)) begin
      @(negedge CLK_I);
      i++;
    end
    if (i == 200) begin
      failures++;
      report_and_stop();
    end
    chk(MAIN_SRC_O, s);
  endtask

  task automatic wait_lock(output int i);
    i = 0;
    while (i < 100 && PLL_LOCK_O !== 1'b1) begin
      @(negedge CLK_I);
      i++;
    end
    if (i == 100) begin
      failures++;
      report_and_stop();
    end
  endtask

  initial begin
    CLK_I = 1'b0;
    RSTN_I = 1'b0;
    {WDT_SEL_I, PLL_EN_I, PLL_REF_SEL_I, MAIN_SEL_WE_I, CLOCK_OUTPUT_PIN_SEL_WE_I, WDT_SEL_WE_I,
     OSC_EN_WE_I, FREQ_WE_I, PLL_EN_WE_I, PLL_CFG_WE_I, CPU_DIV_WE_I, PERIPH_GATE_WE_I,
     PERIPH_DIV_WE_I, SLEEP_REQ_I, WAKE_I, MAIN_SEL_I, CLOCK_OUTPUT_PIN_SEL_I, PLL_LOOP_DIV_I,
     PLL_POST_DIV_I, OSC_EN_I, LFO_FREQ_I, WDO_FREQ_I, PLL_MULT_I, CPU_DIV_I,
     PERIPH_GATE_I, PERIPH_DIV_I, PERIPH_DIV_IDX_I} = '0;
    repeat (10) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    @(negedge CLK_I);
    chk(MAIN_SRC_O, SRC_IRC);
    chk({PLL_PD_O, PLL_BYPASS_O, PLL_LOCK_O}, 3'h6);
    chk({CRYSTAL_OSC_EN_O, LOW_FREQ_OSC_EN_O, WATCHDOG_RING_OSC_EN_O}, 3'h0);
    chk(PLL_POST_RATIO_O, 5'h02);
    wr(MAIN, 16'h0003);
    repeat (20) @(negedge CLK_I);
    chk(MAIN_SRC_O, SRC_IRC);
    wr(OSC, 16'h0007);
    wr(FRQ, 16'h005A);
    @(negedge CLK_I);
    chk({CRYSTAL_OSC_EN_O, LOW_FREQ_OSC_EN_O, WATCHDOG_RING_OSC_EN_O}, 3'h7);
    chk({WDO_FREQ_O, LFO_FREQ_O}, 8'h5A);
    wr(MAIN, 16'(SRC_CRYSTAL));
    wait_src(SRC_CRYSTAL);
    cnt(8, c);
    near(c, 12);
    wr(MAIN, 16'(SRC_LFO));
    wait_src(SRC_LFO);
    cnt(8, c);
    near(c, 8);
    for (int i = 0; i < 4; i++) begin
      wr(OUT, 16'(i));
      repeat (20) @(negedge CLK_I);
      cnt(9, c);
      near(c, 96 / per[i]);
    end
    cnt(10, c);
    near(c, 16);
    wr(WDT, 16'h0001);
    repeat (20) @(negedge CLK_I);
    cnt(10, c);
    near(c, 10);
    for (int i = 0; i < 4; i++) begin
      wr(CFG, 16'h03F0 | 16'(i));
      repeat (3) @(negedge CLK_I);
      chk(PLL_POST_RATIO_O, 16'h0002 << i);
    end
    chk({PLL_MULT_O, PLL_LOOP_DIV_O}, 7'h7C);
    wr(PEN, 16'h0001);
    @(negedge CLK_I);
    chk(PLL_PD_O, 1'b0);
    wait_lock(n);
    chk(16'(n >= SETTLE - 2 && n <= SETTLE + 4), 16'h0001);
    cnt(11, c);
    near(c, 12);
    wr(MAIN, 16'(SRC_PLL));
    wait_src(SRC_PLL);
    cnt(8, c);
    near(c, 24);
    wr(CDIV, 16'h0004);
    repeat (20) @(negedge CLK_I);
    cnt(8, c);
    near(c, 6);
    wr(CDIV, 16'h0001);
    wr(PEN, 16'h0000);
    repeat (3) @(negedge CLK_I);
    chk({PLL_PD_O, PLL_LOCK_O}, 2'h2);
    wait_src(SRC_IRC);
    wr(PEN, 16'h0001);
    wait_lock(n);
    wr(CFG, 16'h03F2);
    repeat (2) @(negedge CLK_I);
    chk(PLL_LOCK_O, 1'b0);
    wr(GATE, 16'h00FB);
    repeat (20) @(negedge CLK_I);
    cnt(2, c);
    chk(16'(c), 16'h0000);
    cnt(3, c);
    near(c, 16);
    wr(GATE, 16'h00FF);
    wr(PDIV, 16'h0003);
    repeat (20) @(negedge CLK_I);
    cnt(0, c);
    near(c, 5);
    wr(SLP, 16'h0000);
    @(negedge CLK_I);
    chk(SLEEPING_O, 1'b1);
    repeat (20) @(negedge CLK_I);
    cnt(8, c);
    chk(16'(c), 16'h0000);
    cnt(3, c);
    near(c, 16);
    wr(WAK, 16'h0000);
    @(negedge CLK_I);
    chk(SLEEPING_O, 1'b0);
    repeat (20) @(negedge CLK_I);
    cnt(8, c);
    near(c, 16);
    wr(MAIN, 16'(SRC_CRYSTAL));
    wait_src(SRC_CRYSTAL);
    // second reset in mid-run must bring back the rc and stop the crystal
    @(posedge CLK_I);
    RSTN_I <= 1'b0;
    repeat (2) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    @(negedge CLK_I);
    chk(MAIN_SRC_O, SRC_IRC);
    chk(CRYSTAL_OSC_EN_O, 1'b0);
    report_and_stop();
  end
endmodule

bind ckm_clock_ctrl ckm_clock_ctrl_chk i_chk (.*);
